//--- rtl/ssp_top.sv
// synchronous serial port, transmit-only and receive-only modes
//
// The Avalon-MM slave port and the placing of the registers were left to the implementer.
`timescale 1ns/1ps
module ssp_top (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic [3:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    input wire logic serial_clock_pin_i,
    output logic serial_clock_pin_o,
    output logic serial_clock_pin_oe,
    output logic data_out_pin,
    input wire logic data_in_pin,
    output logic serial_interrupt_request
);
    import ssp_pkg::*;

    // ----------------------------------------------------------------
    // types and state
    // ----------------------------------------------------------------
    typedef enum logic [2:0] {
        SSP_IDLE = 3'b001,
        SSP_SHIFT = 3'b010,
        SSP_WAIT = 3'b100
    } ssp_state_e;

    ssp_state_e state_reg, state_next;
    logic [7:0] serial_control_reg;
    logic [7:0] div_reg;
    logic [7:0] serial_data_buffer;
    logic [7:0] shift_reg;
    logic [2:0] bit_reg;
    logic [7:0] cnt_reg;
    logic sclk_int_reg;
    logic dout_reg;
    logic tbfl_reg, uerr_reg, rend_reg, oerr_reg, siof_reg;
    logic stop_pend_reg;
    logic irq_reg;
    logic rd_ack_reg;
    logic [31:0] rdata_reg;
    logic sck_s1_reg, sck_s2_reg, sck_s3_reg;
    logic din_s1_reg, din_s2_reg;

    // ----------------------------------------------------------------
    // decode
    // ----------------------------------------------------------------
    wire [1:0] mode_w = serial_control_reg[SSP_CR_MODE_LO +: 2];
    wire [2:0] cks_w = serial_control_reg[SSP_CR_CKS_LO +: 3];
    wire run_w = serial_control_reg[SSP_CR_RUN];
    wire order_w = serial_control_reg[SSP_CR_ORDER];
    wire edge_w = serial_control_reg[SSP_CR_EDGE];
    wire ext_w = (cks_w == SSP_CKS_EXT);
    wire is_tx = (mode_w == SSP_MODE_TX);
    wire is_rx = (mode_w == SSP_MODE_RX);
    wire shifting = (state_reg == SSP_SHIFT);
    wire wr_ctrl = avs_write && avs_address == SSP_ADDR_CTRL;
    wire wr_buf = avs_write && avs_address == SSP_ADDR_BUF;
    wire wr_div = avs_write && avs_address == SSP_ADDR_DIV;
    wire rd_go = avs_read && !rd_ack_reg;
    wire rd_stat = rd_go && avs_address == SSP_ADDR_STAT;
    wire rd_buf = rd_go && avs_address == SSP_ADDR_BUF;
    wire [1:0] new_mode = avs_writedata[SSP_CR_MODE_LO +: 2];
    wire new_run = avs_writedata[SSP_CR_RUN];
    wire abort_w = wr_ctrl && new_mode == SSP_MODE_OFF;
    wire start_w = wr_ctrl && new_run && !run_w && !siof_reg && new_mode != SSP_MODE_OFF;
    wire stop_w = wr_ctrl && !new_run && run_w && siof_reg;
    wire [7:0] sr_w = {siof_reg, shifting, oerr_reg, rend_reg, uerr_reg, tbfl_reg, 2'b00};

    // shift clock edges: internal divider or synchronised external pin
    wire tick_w = (cnt_reg == div_reg);
    wire ext_rise = sck_s2_reg && !sck_s3_reg;
    wire ext_fall = !sck_s2_reg && sck_s3_reg;
    wire int_rise = tick_w && !sclk_int_reg && shifting;
    wire int_fall = tick_w && sclk_int_reg && shifting;
    wire rise_w = ext_w ? ext_rise : int_rise;
    wire fall_w = ext_w ? ext_fall : int_fall;
    wire drive_edge = edge_w ? rise_w : fall_w;
    wire samp_edge = edge_w ? fall_w : rise_w;
    // external clock keeps counting in tx even with empty shifter
    wire tx_drive = is_tx && siof_reg && drive_edge && (shifting || ext_w);
    wire rx_samp = is_rx && shifting && samp_edge;
    wire byte_last = (bit_reg == SSP_LAST_BIT);
    wire tx_done = tx_drive && byte_last && shifting;
    wire rx_done = rx_samp && byte_last;
    wire underrun = tx_drive && !shifting;

    function automatic logic pick_out(input logic [7:0] d, input logic msb);
        pick_out = msb ? d[7] : d[0];
    endfunction : pick_out

    // ----------------------------------------------------------------
    // synchronisers
    // ----------------------------------------------------------------
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            // idle-high reset avoids a false clock edge after reset
            sck_s1_reg <= 1'b1;
            sck_s2_reg <= 1'b1;
            sck_s3_reg <= 1'b1;
            din_s1_reg <= 1'b0;
            din_s2_reg <= 1'b0;
        end else begin
            sck_s1_reg <= serial_clock_pin_i;
            sck_s2_reg <= sck_s1_reg;
            sck_s3_reg <= sck_s2_reg;
            din_s1_reg <= data_in_pin;
            din_s2_reg <= din_s1_reg;
        end
    end

    // ----------------------------------------------------------------
    // control register and divider
    // ----------------------------------------------------------------
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            serial_control_reg <= SSP_CTRL_RST;
            div_reg <= SSP_DIV_RST;
        end else if (abort_w) begin
            serial_control_reg <= SSP_CTRL_RST;
        end else if (wr_ctrl && siof_reg) begin
            serial_control_reg[SSP_CR_RUN] <= new_run;
        end else if (wr_ctrl) begin
            serial_control_reg <= avs_writedata[7:0];
        end else if (wr_div && !siof_reg) begin
            div_reg <= avs_writedata[7:0];
        end
    end

    // ----------------------------------------------------------------
    // state machine
    // ----------------------------------------------------------------
    always_comb begin
        state_next = state_reg;
        case (state_reg)
            SSP_IDLE: begin
                if (start_w && (new_mode == SSP_MODE_TX || new_mode == SSP_MODE_RX))
                    state_next = SSP_SHIFT;
            end
            SSP_SHIFT: begin
                if (tx_done && !tbfl_reg && (stop_pend_reg || !ext_w || !run_w))
                    state_next = stop_pend_reg ? SSP_IDLE : SSP_WAIT;
                else if (tx_done && !tbfl_reg)
                    state_next = SSP_WAIT;
                else if (rx_done)
                    state_next = (stop_pend_reg || (ext_w && !rend_reg)) ?
                        (stop_pend_reg ? SSP_IDLE : SSP_SHIFT) : SSP_WAIT;
            end
            SSP_WAIT: begin
                if (stop_w)
                    state_next = SSP_IDLE;
                else if (is_tx && wr_buf)
                    state_next = SSP_SHIFT;
                else if (is_rx && (rd_buf || ext_w))
                    state_next = SSP_SHIFT;
            end
            default: state_next = SSP_IDLE;
        endcase
        if (abort_w)
            state_next = SSP_IDLE;
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n)
            state_reg <= SSP_IDLE;
        else
            state_reg <= state_next;
    end

    // ----------------------------------------------------------------
    // data path and flags
    // ----------------------------------------------------------------
    wire load_go = state_reg != SSP_SHIFT && state_next == SSP_SHIFT && is_tx
        || state_reg == SSP_IDLE && state_next == SSP_SHIFT && new_mode == SSP_MODE_TX;
    wire reload = tx_done && tbfl_reg;
    wire now_stopped = state_next == SSP_IDLE && state_reg != SSP_IDLE;
    wire tx_irq = (start_w && new_mode == SSP_MODE_TX) || reload
        || (is_tx && state_reg == SSP_WAIT && wr_buf && !stop_w)
        || (is_tx && now_stopped && !abort_w);
    wire rx_irq = rx_done;

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            serial_data_buffer <= 8'h00;
            shift_reg <= 8'h00;
            bit_reg <= 3'h0;
        end else begin
            // first byte is written before the run bit, while mode may still be 00
            if (wr_buf && !is_rx)
                serial_data_buffer <= avs_writedata[7:0];
            else if (rx_done && !rend_reg)
                serial_data_buffer <= order_w ? {shift_reg[6:0], din_s2_reg} :
                    {din_s2_reg, shift_reg[7:1]};
            if (load_go || reload)
                shift_reg <= (wr_buf && state_reg != SSP_SHIFT) ? avs_writedata[7:0] :
                    serial_data_buffer;
            else if (tx_drive && shifting)
                shift_reg <= order_w ? {shift_reg[6:0], 1'b0} : {1'b0, shift_reg[7:1]};
            else if (rx_samp)
                shift_reg <= order_w ? {shift_reg[6:0], din_s2_reg} :
                    {din_s2_reg, shift_reg[7:1]};
            if (state_reg == SSP_IDLE || load_go || reload)
                bit_reg <= 3'h0;
            else if (rx_samp || (tx_drive && shifting))
                bit_reg <= bit_reg + 3'h1;
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            tbfl_reg <= 1'b0;
            uerr_reg <= 1'b0;
            rend_reg <= 1'b0;
            oerr_reg <= 1'b0;
            siof_reg <= 1'b0;
            stop_pend_reg <= 1'b0;
        end else if (abort_w) begin
            {tbfl_reg, uerr_reg, rend_reg, oerr_reg, siof_reg, stop_pend_reg} <= 6'h00;
        end else begin
            if (start_w)
                siof_reg <= 1'b1;
            else if (now_stopped || (stop_w && state_reg != SSP_SHIFT))
                siof_reg <= 1'b0;
            if (stop_w && shifting)
                stop_pend_reg <= 1'b1;
            else if (state_reg == SSP_IDLE)
                stop_pend_reg <= 1'b0;
            if (is_tx && wr_buf && state_reg == SSP_SHIFT && !reload)
                tbfl_reg <= 1'b1;
            else if (reload || now_stopped)
                tbfl_reg <= 1'b0;
            if (underrun)
                uerr_reg <= 1'b1;
            else if (rd_stat)
                uerr_reg <= 1'b0;
            if (rx_done && rend_reg)
                oerr_reg <= 1'b1;
            else if (rd_stat)
                oerr_reg <= 1'b0;
            if (rx_done)
                rend_reg <= 1'b1;
            else if (rd_buf)
                rend_reg <= 1'b0;
        end
    end

    // ----------------------------------------------------------------
    // serial clock and data out
    // ----------------------------------------------------------------
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            cnt_reg <= 8'h00;
            sclk_int_reg <= 1'b1;
            dout_reg <= 1'b1;
        end else begin
            cnt_reg <= (tick_w || !shifting) ? 8'h00 : cnt_reg + 8'h01;
            if (!shifting || ext_w)
                sclk_int_reg <= 1'b1;
            else if (tick_w)
                sclk_int_reg <= !sclk_int_reg;
            // internal clock: last bit stands until the clock has risen, then the line idles high; external clock: last bit is held
            if (abort_w || (state_reg != SSP_SHIFT && !ext_w && sclk_int_reg))
                dout_reg <= 1'b1;
            else if (tx_drive && shifting)
                dout_reg <= pick_out(shift_reg, order_w);
        end
    end

    // ----------------------------------------------------------------
    // bus slave and interrupt
    // ----------------------------------------------------------------
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            rd_ack_reg <= 1'b0;
            rdata_reg <= 32'h0000_0000;
            irq_reg <= 1'b0;
        end else begin
            rd_ack_reg <= rd_go;
            irq_reg <= tx_irq || rx_irq;
            if (rd_go)
                case (avs_address)
                    SSP_ADDR_CTRL: rdata_reg <= {24'h0, serial_control_reg};
                    SSP_ADDR_STAT: rdata_reg <= {24'h0, sr_w};
                    SSP_ADDR_BUF: rdata_reg <= {24'h0, serial_data_buffer};
                    SSP_ADDR_DIV: rdata_reg <= {24'h0, div_reg};
                    default: rdata_reg <= 32'h0000_0000;
                endcase
        end
    end

    assign avs_waitrequest = avs_read && !rd_ack_reg;
    assign avs_readdata = rdata_reg;
    assign serial_clock_pin_o = sclk_int_reg;
    assign serial_clock_pin_oe = !ext_w;
    assign data_out_pin = dout_reg;
    assign serial_interrupt_request = irq_reg;

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    AST_IRQ_PULSE: assert property (@(posedge clk) disable iff (!reset_n)
        serial_interrupt_request |=> !serial_interrupt_request)
        else $error("interrupt longer than one cycle");
    AST_ABORT: assert property (@(posedge clk) disable iff (!reset_n)
        abort_w |=> (sr_w == 8'h00) && data_out_pin && !run_w)
        else $error("mode 00 did not clear");
    AST_UERR_CLR: assert property (@(posedge clk) disable iff (!reset_n)
        rd_stat && !underrun && !abort_w |=> !uerr_reg)
        else $error("status read kept underrun");
    AST_LOCK: assert property (@(posedge clk) disable iff (!reset_n)
        wr_ctrl && siof_reg && !abort_w |=> $stable(serial_control_reg[7:1]))
        else $error("settings changed while busy");
    AST_EXT_OE: assert property (@(posedge clk) disable iff (!reset_n)
        ext_w |-> !serial_clock_pin_oe)
        else $error("external clock pin driven");
    AST_START: assert property (@(posedge clk) disable iff (!reset_n)
        start_w && new_mode == SSP_MODE_TX |=> siof_reg && shifting ##1 !irq_reg)
        else $error("transmit start flags");
    AST_REND: assert property (@(posedge clk) disable iff (!reset_n)
        rx_done && !abort_w |=> rend_reg && irq_reg)
        else $error("receive done not flagged");
    AST_OVR: assert property (@(posedge clk) disable iff (!reset_n)
        rx_done && rend_reg && !abort_w |=> oerr_reg && $stable(serial_data_buffer))
        else $error("overrun handling");
endmodule : ssp_top

//--- rtl/ssp_pkg.sv
// package: constants and register map for the synchronous serial port
// ----------------------------------------------------------------
// ----------------------------------------------------------------
package ssp_pkg;
    localparam logic [3:0] SSP_ADDR_CTRL = 4'h0;
    localparam logic [3:0] SSP_ADDR_STAT = 4'h4;
    localparam logic [3:0] SSP_ADDR_BUF = 4'h8;
    localparam logic [3:0] SSP_ADDR_DIV = 4'hC;
    // control fields
    localparam int SSP_CR_RUN = 0;
    localparam int SSP_CR_MODE_LO = 1;
    localparam int SSP_CR_ORDER = 3;
    localparam int SSP_CR_EDGE = 4;
    localparam int SSP_CR_CKS_LO = 5;
    // status fields
    localparam int SSP_SR_TBFL = 2;
    localparam int SSP_SR_UERR = 3;
    localparam int SSP_SR_REND = 4;
    localparam int SSP_SR_OERR = 5;
    localparam int SSP_SR_SEF = 6;
    localparam int SSP_SR_SIOF = 7;
    localparam logic [1:0] SSP_MODE_OFF = 2'h0;
    localparam logic [1:0] SSP_MODE_TX = 2'h1;
    localparam logic [1:0] SSP_MODE_RX = 2'h2;
    localparam logic [2:0] SSP_CKS_EXT = 3'h7;
    localparam logic [7:0] SSP_CTRL_RST = 8'h00;
    localparam logic [7:0] SSP_DIV_RST = 8'h03;
    localparam logic [2:0] SSP_LAST_BIT = 3'h7;
endpackage : ssp_pkg

//--- test/ssp_peer.sv
// serial peer model: external clock source, byte capture and byte feed
`timescale 1ns/1ps
module ssp_peer (
    input wire logic sclk,
    input wire logic dev_out,
    output logic dev_in,
    output logic ext_clk
);
    logic [7:0] got = 8'h00;
    logic [7:0] feed = 8'hFF;
    int n_got = 0;
    int n_fed = 8;
    initial begin
        dev_in = 1'b1;
        ext_clk = 1'b1;
    end
    // ------------------------------------------------
    // capture on rising, feed on falling
    // ------------------------------------------------
    always @(posedge sclk) begin
        got <= {dev_out, got[7:1]};
        n_got <= n_got + 1;
    end
    // a released line must not look like held data
    always @(negedge sclk) begin
        if (n_fed < 8) begin
            dev_in <= feed[n_fed];
            n_fed <= n_fed + 1;
        end else begin
            dev_in <= ~dev_in;
        end
    end
    task automatic load(input logic [7:0] b);
        feed = b;
        n_fed = 0;
    endtask : load
    // clock stands high outside frames; gap keeps byte spacing
    task automatic ext_byte();
        repeat (8) begin
            #62.5 ext_clk = 1'b0;
            #62.5 ext_clk = 1'b1;
        end
        #200;
    endtask : ext_byte
endmodule : ssp_peer

//--- test/ssp_top_tb.sv
// testbench for the synchronous serial port
`timescale 1ns/1ps
module ssp_top_tb;
    import ssp_pkg::*;
    logic clk;
    logic reset_n;
    logic [3:0] avs_address;
    logic avs_read;
    logic avs_write;
    logic [31:0] avs_writedata;
    logic [31:0] avs_readdata;
    logic avs_waitrequest;
    logic sclk_o;
    logic sclk_oe;
    logic data_out;
    logic data_in;
    logic irq;
    logic irq_q = 1'b0;
    logic ext_clk;
    wire sclk = sclk_oe ? sclk_o : ext_clk;
    int fail_count = 0;
    int n_compared = 0;
    int irq_n = 0;
    int cyc = 0;
    int mark;
    int irq0;
    ssp_top dut_u (.clk(clk), .reset_n(reset_n), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
        .serial_clock_pin_i(sclk), .serial_clock_pin_o(sclk_o),
        .serial_clock_pin_oe(sclk_oe), .data_out_pin(data_out), .data_in_pin(data_in),
        .serial_interrupt_request(irq));
    ssp_peer peer_u (.sclk(sclk), .dev_out(data_out), .dev_in(data_in), .ext_clk(ext_clk));
    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end
    // ------------------------------------------------
    // checks and bus tasks
    // ------------------------------------------------
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        n_compared++;
        if (g !== e) begin
            fail_count++;
            $display("BAD %s expected %h seen %h", nm, e, g);
        end
    endtask : chk
    task automatic tally_and_finish();
        if (fail_count == 0 && n_compared > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : tally_and_finish
    // sampled mid-cycle so registered outputs are settled
    always @(negedge clk) begin
        irq_q <= irq;
        if (irq === 1'b1) irq_n <= irq_n + 1;
        if (irq === 1'b1 && irq_q === 1'b1) chk("irq_width", 0, 1);
    end
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            fail_count++;
            tally_and_finish();
        end
    end
    // request held until the rising edge that sees waitrequest low
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge clk);
        avs_address <= a;
        avs_writedata <= {24'h000000, d};
        avs_write <= 1'b1;
        do @(posedge clk); while (avs_waitrequest !== 1'b0);
        avs_write <= 1'b0;
    endtask : wr
    task automatic rdc(input string nm, input logic [3:0] a, input logic [7:0] e,
        input logic [7:0] m = 8'hFF);
        logic [31:0] got;
        @(posedge clk);
        avs_address <= a;
        avs_read <= 1'b1;
        do @(posedge clk); while (avs_waitrequest !== 1'b0);
        got = avs_readdata;
        avs_read <= 1'b0;
        chk(nm, {24'h000000, e & m}, got & {24'h000000, m});
    endtask : rdc
    // no extra delay: the next byte may start shifting soon after
    task automatic wait_to(input int t);
        for (int i = 0; i < 4000 && peer_u.n_got < t; i++) @(posedge clk);
    endtask : wait_to
    // ------------------------------------------------
    // main sequence
    // ------------------------------------------------
    initial begin
        reset_n = 1'b0;
        avs_address = 4'h0;
        avs_read = 1'b0;
        avs_write = 1'b0;
        avs_writedata = 32'h00000000;
        repeat (3) @(posedge clk);
        reset_n <= 1'b1;
        rdc("ctrl_rst", SSP_ADDR_CTRL, SSP_CTRL_RST);
        rdc("stat_rst", SSP_ADDR_STAT, 8'h00);
        rdc("div_rst", SSP_ADDR_DIV, SSP_DIV_RST);
        wr(4'h2, 8'h5A);
        rdc("unmapped", 4'h2, 8'h00);
        chk("dout_rst", 1, data_out);
        chk("oe_int", 1, sclk_oe);
        // transmit, internal clock, lsb first
        irq0 = irq_n;
        mark = peer_u.n_got;
        wr(SSP_ADDR_BUF, 8'hA5);
        wr(SSP_ADDR_CTRL, 8'h03);
        rdc("tx_start", SSP_ADDR_STAT, 8'hC0);
        wr(SSP_ADDR_CTRL, 8'h1B);
        rdc("ctrl_lock", SSP_ADDR_CTRL, 8'h03);
        wait_to(mark + 8);
        chk("tx_a5", 8'hA5, peer_u.got);
        repeat (24) @(posedge clk);
        rdc("tx_idle", SSP_ADDR_STAT, 8'h80);
        chk("dout_wait", 1, data_out);
        chk("sclk_wait", 1, sclk_o);
        mark = peer_u.n_got;
        wr(SSP_ADDR_BUF, 8'h5A);
        rdc("restart", SSP_ADDR_STAT, 8'hC0);
        wr(SSP_ADDR_BUF, 8'h96);
        rdc("full", SSP_ADDR_STAT, 8'hC4);
        wr(SSP_ADDR_BUF, 8'h69);
        wait_to(mark + 8);
        chk("tx_5a", 8'h5A, peer_u.got);
        repeat (12) @(posedge clk);
        rdc("reload", SSP_ADDR_STAT, 8'hC0);
        wr(SSP_ADDR_CTRL, 8'h02);
        wait_to(mark + 16);
        chk("tx_69", 8'h69, peer_u.got);
        repeat (24) @(posedge clk);
        rdc("drained", SSP_ADDR_STAT, 8'h00);
        chk("tx_irqs", 4, irq_n - irq0);
        chk("dout_stop", 1, data_out);
        // msb first, then stop while waiting
        irq0 = irq_n;
        mark = peer_u.n_got;
        wr(SSP_ADDR_BUF, 8'h1E);
        wr(SSP_ADDR_CTRL, 8'h0B);
        wait_to(mark + 8);
        chk("msb", 8'h78, peer_u.got);
        repeat (24) @(posedge clk);
        wr(SSP_ADDR_CTRL, 8'h0A);
        repeat (4) @(posedge clk);
        rdc("stop_now", SSP_ADDR_STAT, 8'h00);
        chk("stop_irqs", 2, irq_n - irq0);
        // receive, internal clock
        irq0 = irq_n;
        mark = peer_u.n_got;
        peer_u.load(8'h3C);
        wr(SSP_ADDR_CTRL, 8'h05);
        rdc("rx_start", SSP_ADDR_STAT, 8'hC0);
        wait_to(mark + 8);
        repeat (24) @(posedge clk);
        rdc("rx_wait", SSP_ADDR_STAT, 8'h90);
        chk("rx_irq", 1, irq_n - irq0);
        rdc("rx_buf", SSP_ADDR_BUF, 8'h3C);
        rdc("rx_resume", SSP_ADDR_STAT, 8'hC0);
        wr(SSP_ADDR_CTRL, 8'h00);
        repeat (12) @(posedge clk);
        rdc("abort", SSP_ADDR_STAT, 8'h00);
        chk("sclk_abort", 1, sclk_o);
        // receive, external clock, overrun
        wr(SSP_ADDR_CTRL, 8'hE5);
        @(posedge clk);
        chk("oe_ext", 0, sclk_oe);
        peer_u.load(8'hC3);
        peer_u.ext_byte();
        rdc("ext_rx1", SSP_ADDR_STAT, 8'h90, 8'hBF);
        peer_u.load(8'h55);
        peer_u.ext_byte();
        rdc("overrun", SSP_ADDR_STAT, 8'hB0, 8'hBF);
        rdc("kept", SSP_ADDR_BUF, 8'hC3);
        rdc("ovr_clr", SSP_ADDR_STAT, 8'h80, 8'hBF);
        wr(SSP_ADDR_CTRL, 8'h00);
        // transmit, external clock, underrun
        wr(SSP_ADDR_BUF, 8'h4D);
        wr(SSP_ADDR_CTRL, 8'hE3);
        peer_u.ext_byte();
        chk("ext_tx", 8'h4D, peer_u.got);
        chk("dout_hold", 0, data_out);
        peer_u.ext_byte();
        rdc("underrun", SSP_ADDR_STAT, 8'h08, 8'h08);
        rdc("udr_clr", SSP_ADDR_STAT, 8'h00, 8'h08);
        wr(SSP_ADDR_CTRL, 8'h00);
        repeat (4) @(posedge clk);
        chk("dout_abort", 1, data_out);
        tally_and_finish();
    end
endmodule : ssp_top_tb
